// File: src/vfs_pkg.sv
// shared constants, types and lookup tables of the fault supervisor
package vfs_pkg;
  localparam int MV_W = 12;
  localparam int DEG_W = 11;
  // register offsets
  localparam logic [7:0] OFS_OVP_ABS  = 8'h25;
  localparam logic [7:0] OFS_OVP_REL  = 8'h26;
  localparam logic [7:0] OFS_UVP_SEL  = 8'h27;
  localparam logic [7:0] OFS_OTP_SEL  = 8'h28;
  localparam logic [7:0] OFS_PROT_EN  = 8'h29;
  localparam logic [7:0] OFS_FLAGS    = 8'h2a;
  localparam logic [7:0] OFS_DROOP    = 8'h41;
  // field positions
  localparam int BIT_OV = 0;
  localparam int BIT_UV = 1;
  localparam int BIT_OT = 3;
  localparam int DROOP_LSB = 2;
  // reset values and overvoltage knee
  localparam logic [7:0] RST_CFG     = 8'h00;
  localparam logic [7:0] RST_PROT_EN = 8'h1f;
  localparam logic [7:0] RST_RDATA   = 8'h00;
  localparam logic [MV_W-1:0] OVP_KNEE_MV = 12'h532;
  // timing
  localparam int CLK_PERIOD_NS    = 40;
  localparam int OV_DEGLITCH_NS   = 1000;
  localparam int UV_DEGLITCH_NS   = 3000;
  localparam int OT_DEGLITCH_NS   = 45000;
  localparam int OV_STOP_DELAY_NS = 45000;
  localparam int RAMP_STEP_NS     = 2000;
  localparam int REVERT_NS        = 100000;
  localparam int REVERT_STEPS     = 8;
  localparam logic [MV_W-1:0] RAMP_STEP_MV = 12'h003;
  localparam int DEG_CYC [3] = '{
    (OV_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    (UV_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    (OT_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS};
  localparam logic [DEG_W-1:0] OV_STOP_CYC =
    DEG_W'(OV_STOP_DELAY_NS / CLK_PERIOD_NS);
  localparam logic [5:0] RAMP_CYC = 6'(RAMP_STEP_NS / CLK_PERIOD_NS);
  localparam logic [8:0] REVERT_STEP_CYC =
    9'(REVERT_NS / REVERT_STEPS / CLK_PERIOD_NS);
  localparam logic [3:0] REVERT_N = 4'(REVERT_STEPS);

  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_START  = 3'b001,
    ST_RUN    = 3'b010,
    ST_OV_DIS = 3'b011,
    ST_OV_REG = 3'b100,
    ST_OV_STP = 3'b101,
    ST_SHUT   = 3'b110
  } vfs_state_t;

  typedef enum logic [1:0] {
    PWM_RUN  = 2'b00,
    PWM_LOW  = 2'b01,
    PWM_TRI  = 2'b10
  } vfs_pwm_t;

  typedef struct packed {
    logic [7:0] ovp_abs;
    logic [7:0] ovp_rel;
    logic [7:0] uvp_sel;
    logic [7:0] otp_sel;
    logic [7:0] prot_en;
    logic [7:0] droop;
  } vfs_cfg_t;

  // all voltages in mV, temperature in degrees C
  typedef struct packed {
    logic [MV_W-1:0] output_sense;
    logic [MV_W-1:0] reference_input_voltage;
    logic [MV_W-1:0] voltage_target;
    logic [MV_W-1:0] current_sense_sum;
    logic [7:0]      die_temp;
  } vfs_sense_t;

  function automatic logic [MV_W-1:0] ovp_abs_mv(input logic [1:0] s);
    case (s)
      2'b00:   return 12'h7d0;
      2'b01:   return 12'h708;
      2'b10:   return 12'h898;
      default: return 12'h960;
    endcase
  endfunction

  // relative factor in quarters: 1.5, 1.25, 1.75, 2.0
  function automatic logic [3:0] ovp_rel_q4(input logic [1:0] s);
    case (s)
      2'b00:   return 4'h6;
      2'b01:   return 4'h5;
      2'b10:   return 4'h7;
      default: return 4'h8;
    endcase
  endfunction

  // undervoltage factor in tenths: 0.4, 0.3, 0.5, 0.6
  function automatic logic [3:0] uvp_k10(input logic [1:0] s);
    case (s)
      2'b00:   return 4'h4;
      2'b01:   return 4'h3;
      2'b10:   return 4'h5;
      default: return 4'h6;
    endcase
  endfunction

  function automatic logic [7:0] otp_limit_c(input logic [1:0] s);
    case (s)
      2'b00:   return 8'h96;
      2'b01:   return 8'h7d;
      2'b10:   return 8'h87;
      default: return 8'ha0;
    endcase
  endfunction

  function automatic logic [5:0] droop_gain(input logic [1:0] s,
                                            input logic smart);
    case (s)
      2'b00:   return smart ? 6'h0c : 6'h30;
      2'b01:   return smart ? 6'h06 : 6'h18;
      2'b10:   return smart ? 6'h03 : 6'h0c;
      default: return smart ? 6'h02 : 6'h06;
    endcase
  endfunction
endpackage

// File: src/vfs_deglitch.sv
// deglitch timer: trips once a condition holds longer than CYC cycles
`timescale 1ns/1ps
module vfs_deglitch #(
  parameter int CYC = 25
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // condition and trip level
  input  wire logic cond,
  output logic      trip
);
  typedef struct packed {
    logic [vfs_pkg::DEG_W-1:0] cnt;
    logic                      trip;
  } vfs_deg_st_t;

  localparam logic [vfs_pkg::DEG_W-1:0] LIM = vfs_pkg::DEG_W'(CYC);

  vfs_deg_st_t s;
  vfs_deg_st_t next_s;

  always_comb begin
    next_s = s;
    if (!cond) begin
      next_s.cnt = '0;
    end else if (s.cnt != LIM) begin
      next_s.cnt = s.cnt + 1'b1;
    end
    next_s.trip = cond && (s.cnt == LIM);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign trip = s.trip;
endmodule

// File: src/vfs_regs.sv
// register file of the fault supervisor
`timescale 1ns/1ps
module vfs_regs (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // register port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // block side
  input  wire logic [7:0] fault_flags,
  output vfs_pkg::vfs_cfg_t cfg
);
  typedef struct packed {
    vfs_pkg::vfs_cfg_t cfg;
    logic [7:0]        rdata;
  } vfs_reg_st_t;

  vfs_reg_st_t s;
  vfs_reg_st_t next_s;

  always_comb begin
    next_s = s;
    if (reg_wr) begin
      case (reg_addr)
        vfs_pkg::OFS_OVP_ABS: next_s.cfg.ovp_abs = reg_wdata;
        vfs_pkg::OFS_OVP_REL: next_s.cfg.ovp_rel = reg_wdata;
        vfs_pkg::OFS_UVP_SEL: next_s.cfg.uvp_sel = reg_wdata;
        vfs_pkg::OFS_OTP_SEL: next_s.cfg.otp_sel = reg_wdata;
        vfs_pkg::OFS_PROT_EN: next_s.cfg.prot_en = reg_wdata;
        vfs_pkg::OFS_DROOP:   next_s.cfg.droop   = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        vfs_pkg::OFS_OVP_ABS: next_s.rdata = s.cfg.ovp_abs;
        vfs_pkg::OFS_OVP_REL: next_s.rdata = s.cfg.ovp_rel;
        vfs_pkg::OFS_UVP_SEL: next_s.rdata = s.cfg.uvp_sel;
        vfs_pkg::OFS_OTP_SEL: next_s.rdata = s.cfg.otp_sel;
        vfs_pkg::OFS_PROT_EN: next_s.rdata = s.cfg.prot_en;
        vfs_pkg::OFS_FLAGS:   next_s.rdata = fault_flags;
        vfs_pkg::OFS_DROOP:   next_s.rdata = s.cfg.droop;
        default:              next_s.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s.cfg.ovp_abs <= vfs_pkg::RST_CFG;
      s.cfg.ovp_rel <= vfs_pkg::RST_CFG;
      s.cfg.uvp_sel <= vfs_pkg::RST_CFG;
      s.cfg.otp_sel <= vfs_pkg::RST_CFG;
      s.cfg.prot_en <= vfs_pkg::RST_PROT_EN;
      s.cfg.droop   <= vfs_pkg::RST_CFG;
      s.rdata       <= vfs_pkg::RST_RDATA;
    end else begin
      s <= next_s;
    end
  end

  assign cfg       = s.cfg;
  assign reg_rdata = s.rdata;
endmodule

// File: src/vfs_supervisor.sv
// fault supervisor, power-good and droop target control for a vr controller
`timescale 1ns/1ps
// Functional notes
// - power-good stays low throughout soft-start
// - power-good rises and latches once output reaches reference
// - any protection trip or enable fall pulls power-good low at once
// - reference below 1.33V: absolute overvoltage level, selectable
// - reference above 1.33V: reference times selectable factor
// - overvoltage needs sense above threshold longer than 1us
// - overvoltage: power-good low, negative discharge on, flag bit 0
// - after trip hold pwm low to target, then regulate until 45us
// - from 45us ramp target down 1.5mV/us; tri-state above, low below
// - faults and flags latch until enable re-toggle or power reset
// - enable bits gate only the action; flags always set
// - undervoltage over 3us: pwm tri-state, discharge switch on
// - undervoltage: power-good low and flag bit 1
// - undervoltage threshold selectable, default 0.4 times reference
// - undervoltage masked until power-good has first gone high
// - die temperature over limit longer than 45us: pwm tri-state
// - over-temperature: power-good low and flag bit 3
// - load step swaps in short-term target from summed sense gain
// - two-bit field selects droop gain per sensing mode
// - short-term target returns to normal over about 100us
module vfs_supervisor (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // register port
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  output logic      [7:0]         reg_rdata,
  // measurements and controls
  input  wire vfs_pkg::vfs_sense_t sense,
  input  wire logic               chip_enable_pin,
  input  wire logic               load_step,
  input  wire logic               smart_stage_sensing,
  input  wire logic [7:0]         error_amp_gain,
  // power stage controls
  output vfs_pkg::vfs_pwm_t       pwm_mode,
  output logic                    output_discharge_on,
  output logic                    negative_voltage_discharge,
  output logic [vfs_pkg::MV_W-1:0] target_out,
  // open-drain power-good pin
  output logic                    power_good_out,
  output logic                    power_good_oe
);
  localparam int W = vfs_pkg::MV_W;

  typedef struct packed {
    logic                     en_s1;
    logic                     en_s2;
    logic                     en_s3;
    logic                     en_f;
    vfs_pkg::vfs_state_t      fsm;
    logic [7:0]               flags;
    logic                     pg;
    logic                     pg_seen;
    logic [vfs_pkg::DEG_W-1:0] ov_cnt;
    logic [5:0]               ramp_cnt;
    logic [W-1:0]             stop_tgt;
    logic [W-1:0]             droop_off;
    logic [W-1:0]             droop_step;
    logic [8:0]               rev_cnt;
    logic [3:0]               rev_left;
    vfs_pkg::vfs_pwm_t        pwm;
    logic                     dis_on;
    logic                     nvd_on;
    logic [W-1:0]             tgt;
    logic                     pg_oe;
    logic                     pg_pin;
  } vfs_st_t;

  vfs_st_t           s;
  vfs_st_t           next_s;
  vfs_pkg::vfs_cfg_t cfg;
  logic [2:0]        trip;
  logic [2:0]        cond;

  vfs_regs u_regs (
    .clk         (clk),
    .rst         (rst),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_rdata   (reg_rdata),
    .fault_flags (s.flags),
    .cfg         (cfg)
  );

  // one deglitch timer per fault: 0 over, 1 under, 2 temperature
  for (genvar i = 0; i < 3; i++) begin : g_deg
    vfs_deglitch #(.CYC(vfs_pkg::DEG_CYC[i])) u_deg (
      .clk  (clk),
      .rst  (rst),
      .cond (cond[i]),
      .trip (trip[i])
    );
  end

  // threshold comparison
  logic [15:0] sense_x4;
  logic [15:0] sense_x10;
  logic [15:0] ref_rel;
  logic [15:0] ref_uv;
  logic        ov_above;
  logic        uv_below;
  logic        ot_above;

  always_comb begin
    sense_x4  = 16'(sense.output_sense) << 2;
    sense_x10 = 16'(sense.output_sense) * 16'h000a;
    ref_rel   = 16'(sense.reference_input_voltage)
              * 16'(vfs_pkg::ovp_rel_q4(cfg.ovp_rel[1:0]));
    ref_uv    = 16'(sense.reference_input_voltage)
              * 16'(vfs_pkg::uvp_k10(cfg.uvp_sel[1:0]));
    if (sense.reference_input_voltage < vfs_pkg::OVP_KNEE_MV) begin
      ov_above = sense.output_sense
               > vfs_pkg::ovp_abs_mv(cfg.ovp_abs[1:0]);
    end else begin
      ov_above = sense_x4 > ref_rel;
    end
    uv_below = sense_x10 < ref_uv;
    ot_above = sense.die_temp
             > vfs_pkg::otp_limit_c(cfg.otp_sel[1:0]);
    cond[0] = s.en_f && ov_above;
    cond[1] = s.en_f && s.pg_seen && uv_below;
    cond[2] = ot_above;
  end

  // short-term target offset from summed current sense
  logic [17:0] droop_prod;
  logic [17:0] droop_quot;
  logic [7:0]  gdiv;
  logic [W-1:0] droop_new;

  always_comb begin
    gdiv = (error_amp_gain == 8'h00) ? 8'h01 : error_amp_gain;
    droop_prod = 18'(sense.current_sense_sum)
               * 18'(vfs_pkg::droop_gain(
                   cfg.droop[vfs_pkg::DROOP_LSB+:2],
                   smart_stage_sensing));
    if (smart_stage_sensing) begin
      droop_prod = droop_prod >> 3;
    end
    droop_quot = droop_prod / 18'(gdiv);
    droop_new  = (droop_quot[17:W] != '0) ? '1 : droop_quot[W-1:0];
  end

  // main sequencer
  logic       en_rise;
  logic [7:0] det;
  logic       act_ov;
  logic       act_uv;
  logic       act_ot;
  logic       healthy;

  always_comb begin
    next_s = s;
    next_s.en_s1 = chip_enable_pin;
    next_s.en_s2 = s.en_s1;
    next_s.en_s3 = s.en_s2;
    if (s.en_s2 == s.en_s3) begin
      next_s.en_f = s.en_s3;
    end
    en_rise = (s.en_s2 == s.en_s3) && s.en_s3 && !s.en_f;

    det = 8'h00;
    det[vfs_pkg::BIT_OV] = trip[0];
    det[vfs_pkg::BIT_UV] = trip[1];
    det[vfs_pkg::BIT_OT] = trip[2];
    // set wins over the clear on the enable rising edge
    if (en_rise) begin
      next_s.flags = 8'h00;
    end
    next_s.flags = next_s.flags | det;
    act_ov = trip[0] && cfg.prot_en[vfs_pkg::BIT_OV];
    act_uv = trip[1] && cfg.prot_en[vfs_pkg::BIT_UV];
    act_ot = trip[2] && cfg.prot_en[vfs_pkg::BIT_OT];
    healthy = (s.fsm == vfs_pkg::ST_START) || (s.fsm == vfs_pkg::ST_RUN);

    unique case (s.fsm)
      vfs_pkg::ST_OFF: begin
        next_s.pwm = vfs_pkg::PWM_TRI;
        next_s.pg = 1'b0;
        next_s.pg_seen = 1'b0;
        next_s.dis_on = 1'b0;
        next_s.nvd_on = 1'b0;
        if (s.en_f) begin
          next_s.fsm = vfs_pkg::ST_START;
          next_s.pwm = vfs_pkg::PWM_RUN;
        end
      end
      vfs_pkg::ST_START: begin
        next_s.pg = 1'b0;
        if (sense.output_sense >= sense.reference_input_voltage) begin
          next_s.pg = 1'b1;
          next_s.pg_seen = 1'b1;
          next_s.fsm = vfs_pkg::ST_RUN;
        end
      end
      vfs_pkg::ST_RUN: begin
        next_s.pg = 1'b1;
      end
      vfs_pkg::ST_OV_DIS, vfs_pkg::ST_OV_REG: begin
        next_s.ov_cnt = s.ov_cnt + 1'b1;
        if (s.fsm == vfs_pkg::ST_OV_DIS &&
            sense.output_sense > sense.voltage_target) begin
          next_s.pwm = vfs_pkg::PWM_LOW;
        end else begin
          next_s.fsm = vfs_pkg::ST_OV_REG;
          next_s.pwm = (sense.output_sense > sense.voltage_target)
                     ? vfs_pkg::PWM_LOW : vfs_pkg::PWM_TRI;
        end
        if (s.ov_cnt == vfs_pkg::OV_STOP_CYC - 2'd2) begin
          next_s.fsm = vfs_pkg::ST_OV_STP;
          next_s.stop_tgt = sense.voltage_target;
          next_s.ramp_cnt = '0;
        end
      end
      vfs_pkg::ST_OV_STP: begin
        next_s.ramp_cnt = s.ramp_cnt + 1'b1;
        if (s.ramp_cnt == vfs_pkg::RAMP_CYC - 1'b1) begin
          next_s.ramp_cnt = '0;
          next_s.stop_tgt = (s.stop_tgt > vfs_pkg::RAMP_STEP_MV)
                          ? s.stop_tgt - vfs_pkg::RAMP_STEP_MV
                          : '0;
        end
        next_s.pwm = (sense.output_sense > s.stop_tgt)
                   ? vfs_pkg::PWM_TRI : vfs_pkg::PWM_LOW;
      end
      vfs_pkg::ST_SHUT: begin
        next_s.pwm = vfs_pkg::PWM_TRI;
      end
      default: begin
        next_s.fsm = vfs_pkg::ST_OFF;
      end
    endcase

    // only a healthy sequencer takes a new fault action
    if (healthy) begin
      if (act_ov) begin
        next_s.fsm = vfs_pkg::ST_OV_DIS;
        next_s.nvd_on = 1'b1;
        next_s.pwm = vfs_pkg::PWM_LOW;
        next_s.ov_cnt = '0;
      end else if (act_uv || act_ot) begin
        next_s.fsm = vfs_pkg::ST_SHUT;
        next_s.pwm = vfs_pkg::PWM_TRI;
        next_s.dis_on = act_uv;
      end
    end
    if (det != 8'h00) begin
      next_s.pg = 1'b0;
    end
    if (!s.en_f) begin
      next_s.fsm = vfs_pkg::ST_OFF;
      next_s.pg = 1'b0;
      next_s.pwm = vfs_pkg::PWM_TRI;
      next_s.dis_on = 1'b0;
      next_s.nvd_on = 1'b0;
    end

    // transient droop offset and its staged return
    if (load_step && s.fsm == vfs_pkg::ST_RUN) begin
      next_s.droop_off = droop_new;
      next_s.droop_step = (droop_new >> 3) | W'(1);
      next_s.rev_cnt = '0;
      next_s.rev_left = vfs_pkg::REVERT_N;
    end else if (s.rev_left != 4'h0) begin
      next_s.rev_cnt = s.rev_cnt + 1'b1;
      if (s.rev_cnt == vfs_pkg::REVERT_STEP_CYC - 1'b1) begin
        next_s.rev_cnt = '0;
        next_s.rev_left = s.rev_left - 1'b1;
        if (s.rev_left == 4'h1 || s.droop_off <= s.droop_step) begin
          next_s.droop_off = '0;
        end else begin
          next_s.droop_off = s.droop_off - s.droop_step;
        end
      end
    end
    if (s.fsm != vfs_pkg::ST_RUN) begin
      next_s.droop_off = '0;
      next_s.rev_left = 4'h0;
    end

    if (next_s.fsm == vfs_pkg::ST_OV_STP) begin
      next_s.tgt = next_s.stop_tgt;
    end else if (sense.voltage_target > next_s.droop_off) begin
      next_s.tgt = sense.voltage_target - next_s.droop_off;
    end else begin
      next_s.tgt = '0;
    end
    next_s.pg_oe = !next_s.pg;
    next_s.pg_pin = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.fsm <= vfs_pkg::ST_OFF;
      s.pwm <= vfs_pkg::PWM_TRI;
      s.pg_oe <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign pwm_mode                   = s.pwm;
  assign output_discharge_on        = s.dis_on;
  assign negative_voltage_discharge = s.nvd_on;
  assign target_out                 = s.tgt;
  assign power_good_out             = s.pg_pin;
  assign power_good_oe              = s.pg_oe;
endmodule

// File: bench/vfs_supervisor_assertions.sv
// port checks of the fault supervisor
`timescale 1ns/1ps
module vfs_supervisor_assertions (
  // clock and reset
  input wire logic                     clk,
  input wire logic                     rst,
  // watched ports
  input wire vfs_pkg::vfs_sense_t      sense,
  input wire vfs_pkg::vfs_pwm_t        pwm_mode,
  input wire logic                     output_discharge_on,
  input wire logic                     negative_voltage_discharge,
  input wire logic [vfs_pkg::MV_W-1:0] target_out,
  input wire logic                     power_good_out,
  input wire logic                     power_good_oe
);
  logic [7:0] hi_cnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // samples in a row above the lowest reachable overvoltage level
  always_ff @(posedge clk) begin
    if (rst || sense.output_sense <= 12'h67e) begin
      hi_cnt <= 8'h00;
    end else if (hi_cnt != 8'hff) begin
      hi_cnt <= hi_cnt + 8'h01;
    end
  end
  AST_OV_DEGLITCH: assert property (
    $rose(negative_voltage_discharge) |-> hi_cnt >= 8'h14)
    else $error("overvoltage action without a long violation");
  AST_OV_ACTION: assert property (
    $rose(negative_voltage_discharge) |->
      pwm_mode == vfs_pkg::PWM_LOW ##[0:1] power_good_oe)
    else $error("overvoltage action incomplete");
  AST_UV_ACTION: assert property (
    $rose(output_discharge_on) |->
      ##[0:1] (pwm_mode == vfs_pkg::PWM_TRI && power_good_oe))
    else $error("undervoltage action incomplete");
  AST_PG_RELEASE: assert property (
    $fell(power_good_oe) |-> pwm_mode == vfs_pkg::PWM_RUN &&
      !negative_voltage_discharge && !output_discharge_on)
    else $error("power-good released outside normal running");
  AST_PG_FAULT: assert property (
    negative_voltage_discharge || output_discharge_on |->
      power_good_oe && !power_good_out)
    else $error("power-good not pulled low during a fault");
  AST_FIRST_OWNS: assert property (
    negative_voltage_discharge ##1 negative_voltage_discharge |->
      !output_discharge_on)
    else $error("later fault took over the power stage");
  AST_SS_PWM: assert property (
    negative_voltage_discharge && target_out > 12'h000 &&
      target_out < sense.voltage_target && $stable(sense.output_sense)
      |=> !negative_voltage_discharge || pwm_mode ==
      ($past(sense.output_sense) > $past(target_out) ?
       vfs_pkg::PWM_TRI : vfs_pkg::PWM_LOW))
    else $error("soft-stop pwm level wrong");
  AST_RESET_VAL: assert property (
    $fell(rst) |-> power_good_oe && pwm_mode == vfs_pkg::PWM_TRI &&
      target_out == 12'h000)
    else $error("outputs not at reset values");
  COV_OV: cover property ($rose(negative_voltage_discharge));
  COV_UV: cover property ($rose(output_discharge_on));
  COV_PG: cover property ($fell(power_good_oe));
endmodule

// File: bench/vfs_stage_model.sv
// power-good pin model with its pull-up
`timescale 1ns/1ps
module vfs_stage_model (
  // pin drive from the supervisor
  input  wire logic power_good_out,
  input  wire logic power_good_oe,
  // resolved pin level
  output logic      pg_wire
);
  // the pull-up wins whenever nobody drives the pin
  assign pg_wire = power_good_oe ? power_good_out : 1'b1;
endmodule

// File: bench/vfs_supervisor_tb_top.sv
// self-checking bench of the fault supervisor
`timescale 1ns/1ps
module vfs_supervisor_tb_top;
  logic                clk, rst, reg_wr, reg_rd, load_step, smart, odo, nvd;
  logic                chip_enable_pin, power_good_out, power_good_oe;
  logic                pg_wire;
  logic [7:0]          reg_addr, reg_wdata, reg_rdata, error_amp_gain, rd;
  logic [11:0]         target_out, thr, cs;
  logic [31:0]         lfsr;
  vfs_pkg::vfs_sense_t sense;
  vfs_pkg::vfs_pwm_t   pwm_mode;
  int                  mismatches, checks_done, n;
  localparam logic [7:0] AD [8] = '{8'h25, 8'h26, 8'h27, 8'h28, 8'h29,
                                   8'h2a, 8'h41, 8'h30};
  localparam logic [7:0] RV [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h1f,
                                   8'h00, 8'h00, 8'h00};
  localparam logic [15:0] QF [4] = '{16'h6, 16'h5, 16'h7, 16'h8};
  localparam logic [11:0] OA [4] = '{12'h7d0, 12'h708, 12'h898, 12'h960};
  localparam logic [15:0] DG [8] = '{16'h30, 16'h18, 16'hc, 16'h6,
                                    16'hc, 16'h6, 16'h3, 16'h2};
  vfs_supervisor dut_u (.*, .smart_stage_sensing(smart),
    .output_discharge_on(odo), .negative_voltage_discharge(nvd));
  vfs_stage_model pm_u (.*);
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [11:0] ovt(input logic m, input logic [1:0] s,
                                      input logic [11:0] r);
    return m ? 12'((16'(r) * QF[s]) / 16'h4) : OA[s];
  endfunction
  function automatic logic [11:0] drp(input logic [2:0] k,
                                      input logic [11:0] c);
    logic [15:0] x;
    x = 16'(c) * DG[k];
    return 12'((k[2] ? x / 16'h8 : x) / 16'h4);
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic cmp(input string w, input logic [11:0] e,
                     input logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic lim(input int k);
    if (n >= k) begin
      mismatches++;
      $display("Error wait expected done seen timeout");
      wrap_up();
    end
  endtask
  task automatic waitv(ref logic s, input logic v, input int k);
    n = 0;
    while (s !== v && n < k) begin
      tick(1);
      n++;
    end
    lim(k);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rdr(input logic [7:0] a);
    reg_rd = 1'b1;
    reg_addr = a;
    tick(1);
    reg_rd = 1'b0;
    rd = reg_rdata;
    tick(1);
  endtask
  // enable re-toggle, soft-start and release of power-good
  task automatic restart(input logic [11:0] r);
    chip_enable_pin = 1'b0;
    tick(10);
    sense.reference_input_voltage = r;
    sense.voltage_target = r;
    sense.output_sense = 12'h000;
    chip_enable_pin = 1'b1;
    tick(100);
    cmp("soft-start pg", 12'h000, {11'h0, pg_wire});
    rdr(8'h2a);
    cmp("flags after enable", 12'h000, {4'h0, rd});
    sense.output_sense = r;
    waitv(power_good_oe, 1'b0, 60);
    sense.output_sense = r - 12'h032;
    tick(20);
    cmp("pg latched", 12'h001, {11'h0, pg_wire});
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {rst, reg_wr, reg_rd, load_step, smart, chip_enable_pin} = 6'b100000;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    error_amp_gain = 8'h04;
    sense = '0;
    sense.die_temp = 8'h19;
    lfsr = 32'he01abd88;
    mismatches = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    tick(1);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      rdr(AD[i]);
      cmp("reset value", {4'h0, RV[i]}, {4'h0, rd});
      lfsr = nxt(lfsr);
      wr(AD[i], lfsr[7:0]);
      rdr(AD[i]);
      cmp("read back", (i > 4 && i != 6) ? 12'h0 : {4'h0, lfsr[7:0]},
          {4'h0, rd});
      wr(AD[i], RV[i]);
    end
    $display("registers done");
    for (int i = 0; i < 8; i++) begin
      wr(i[2] ? 8'h26 : 8'h25, {6'h00, 2'(i)});
      restart(i[2] ? 12'h578 : 12'h3e8);
      thr = ovt(i[2], 2'(i), sense.reference_input_voltage);
      sense.output_sense = thr;
      tick(40);
      cmp("ov at threshold", 12'h000, {11'h0, nvd});
      sense.output_sense = thr + 12'h001;
      tick(20);
      sense.output_sense = thr;
      tick(1);
      sense.output_sense = thr + 12'h001;
      waitv(nvd, 1'b1, 60);
      cmp("ov deglitch", 12'h001, {11'h0, n > 25});
      tick(2);
      cmp("ov pwm", 12'h001, {10'h0, pwm_mode});
      cmp("ov pg", 12'h000, {11'h0, pg_wire});
      rdr(8'h2a);
      cmp("ov flag", 12'h001, {4'h0, rd});
    end
    tick(10);
    cmp("discharge pwm", 12'h001, {10'h0, pwm_mode});
    sense.output_sense = 12'h56e;
    tick(5);
    cmp("regulate pwm", 12'h002, {10'h0, pwm_mode});
    n = 0;
    while (target_out !== 12'h575 && n < 1400) begin
      tick(1);
      n++;
    end
    lim(1400);
    cmp("soft-stop start", 12'h001, {11'h0, n > 1090});
    sense.output_sense = 12'h064;
    tick(100);
    cmp("soft-stop low", 12'h001, {10'h0, pwm_mode});
    cmp("later uv action", 12'h000, {11'h0, odo});
    rdr(8'h2a);
    cmp("later uv flag", 12'h003, {4'h0, rd});
    sense.output_sense = 12'h578;
    tick(4);
    cmp("soft-stop tri", 12'h002, {10'h0, pwm_mode});
    cmp("soft-stop step", 12'h000, (12'h578 - target_out) % 12'h3);
    wr(8'h25, 8'h00);
    wr(8'h26, 8'h00);
    $display("overvoltage done");
    wr(8'h29, 8'h1e);
    restart(12'h3e8);
    sense.output_sense = 12'h7d1;
    tick(40);
    rdr(8'h2a);
    cmp("disabled flag", 12'h001, {4'h0, rd});
    cmp("disabled pwm", 12'h000, {10'h0, pwm_mode});
    cmp("disabled discharge", 12'h000, {11'h0, nvd});
    wr(8'h29, 8'h1f);
    restart(12'h3e8);
    sense.output_sense = 12'h190;
    tick(100);
    cmp("uv at threshold", 12'h000, {11'h0, odo});
    sense.output_sense = 12'h18f;
    waitv(odo, 1'b1, 100);
    cmp("uv deglitch", 12'h001, {11'h0, n > 75});
    tick(2);
    cmp("uv pwm", 12'h002, {10'h0, pwm_mode});
    cmp("uv pg", 12'h000, {11'h0, pg_wire});
    rdr(8'h2a);
    cmp("uv flag", 12'h002, {4'h0, rd});
    $display("undervoltage done");
    restart(12'h3e8);
    sense.die_temp = 8'h96;
    tick(1200);
    cmp("ot at limit", 12'h000, {10'h0, pwm_mode});
    sense.die_temp = 8'h97;
    n = 0;
    while (pwm_mode !== vfs_pkg::PWM_TRI && n < 1300) begin
      tick(1);
      n++;
    end
    lim(1300);
    cmp("ot deglitch", 12'h001, {11'h0, n > 1125});
    tick(2);
    rdr(8'h2a);
    cmp("ot flag", 12'h008, {4'h0, rd});
    cmp("ot pg", 12'h000, {11'h0, pg_wire});
    sense.die_temp = 8'h19;
    $display("temperature done");
    restart(12'h3e8);
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      cs = 12'h010 + {6'h00, lfsr[5:0]};
      wr(8'h41, {4'h0, 2'(i), 2'b00});
      smart = i[2];
      sense.current_sense_sum = cs;
      load_step = 1'b1;
      tick(1);
      load_step = 1'b0;
      n = 0;
      while (target_out === 12'h3e8 && n < 5) begin
        tick(1);
        n++;
      end
      lim(5);
      thr = 12'h3e8 - drp(3'(i), cs);
      cmp("droop target", thr, target_out);
      tick(2700);
      cmp("droop revert", 12'h3e8, target_out);
    end
    $display("droop done");
    wrap_up();
  end
endmodule
bind vfs_supervisor vfs_supervisor_assertions chk_u (.*);
